/* sr_gate_pkg.sv */
// constants for the synchronous rectifier gate timing controller
package sr_gate_pkg;
   localparam int CLK_MHZ = 40;
   localparam int CLK_PERIOD_NS = 25;
   // times in their own units
   localparam int INIT_MIN_US = 150;
   localparam int INIT_MAX_US = 250;
   localparam int LOGIC_INIT_US = 20;
   localparam int SAMPLE_WIN_NS = 100;
   localparam int MIN_ON_NS = 350;
   localparam int OFF_BLANK_NS = 4350;
   localparam int ENTRY_WIN_US = 12800;
   localparam int EXIT_WIN_US = 2560;
   // cycle counts: least times round up
   localparam int INIT_CYC = INIT_MIN_US * CLK_MHZ;
   localparam int LOGIC_INIT_CYC = LOGIC_INIT_US * CLK_MHZ;
   localparam int SAMPLE_WIN_CYC =
      (SAMPLE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_BLANK_CYC =
      (OFF_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ENTRY_WIN_CYC = ENTRY_WIN_US * CLK_MHZ;
   localparam int EXIT_WIN_CYC = EXIT_WIN_US * CLK_MHZ;
   localparam int ENTRY_CYCLES = 64;
   localparam int EXIT_CYCLES = 32;
   // dynamic threshold fraction, percent
   localparam int THRESH_PCT = 85;
   localparam int BLANK_W = 8;
   localparam int LEVEL_W = 8;
   localparam int TIMER_W = 20;
   localparam int EVT_W = 8;
   typedef enum logic [1:0] {SEQ_OFF, SEQ_INIT, SEQ_LOGIC, SEQ_RUN} seq_t;
endpackage

/* sr_gate_timing_controller.sv */
// sequencing and gate timing core of the synchronous rectifier controller
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - supply valid above start level, invalid below lower stop level.
// - after supply valid, run startup init interval before any enabling step.
// - then logic init interval; at its end blanking reference enables.
// - drive disabled until qualified primary pulse and output sense enabled.
// - both ramps start when primary sense exceeds enable and dynamic levels.
// - pulse qualifies only above thresholds longer than blanking time.
// - primary ramp rises until primary falling edge, then holds peak.
// - drive on at falling edge near zero, off when ramps cross.
// - both ramps cleared on every primary rising edge in run, before the pulse is qualified.
// - rising edge starts blank timer; expiry opens sample window, arms drive.
// - next dynamic threshold is 85 percent of sampled level.
// - blanking duration configurable through blanking set pin.
// - drive stays on for at least minimum on time while in run and not in standby.
// - drive falling edge starts off blank timer blocking turn on.
// - primary ramp saturation shortens drive on time.
// - average frequency selects standby; standby holds drive off.
// - start normal; enter standby under 64 cycles in entry window.
// - leave standby at once when over 32 cycles in exit window.
module sr_gate_timing_controller #(
   parameter int INIT_CYC = sr_gate_pkg::INIT_CYC,
   parameter int ENTRY_WIN_CYC = sr_gate_pkg::ENTRY_WIN_CYC,
   parameter int EXIT_WIN_CYC = sr_gate_pkg::EXIT_WIN_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic supply_above_start,
   input wire logic supply_above_stop,
   input wire logic primary_above_enable,
   input wire logic primary_above_adaptive,
   input wire logic primary_near_zero,
   input wire logic output_above_enable,
   input wire logic ramp_crossed,
   input wire logic primary_ramp_saturated,
   input wire logic [sr_gate_pkg::LEVEL_W-1:0] primary_level,
   input wire logic [sr_gate_pkg::BLANK_W-1:0] blanking_set_pin,
   output logic gate_drive_out,
   output logic ramp_clear,
   output logic primary_ramp_run,
   output logic secondary_ramp_run,
   output logic level_sample_active,
   output logic blank_reference_enable,
   output logic [sr_gate_pkg::LEVEL_W-1:0] adaptive_pulse_level,
   output logic standby_mode
);
   localparam int TW = sr_gate_pkg::TIMER_W;
   localparam int EW = sr_gate_pkg::EVT_W;
   localparam int LW = sr_gate_pkg::LEVEL_W;

   // ----------------------------------------------------------------
   // supply and start-up sequence
   // ----------------------------------------------------------------
   sr_gate_pkg::seq_t seq_r, seq_nxt;
   logic supply_ok_r;
   logic [TW-1:0] seq_cnt_r;
   wire supply_ok_nxt = supply_ok_r ? supply_above_stop
                                    : supply_above_start;
   wire supply_drop = supply_ok_r && !supply_above_stop;
   wire seq_done = (seq_r == sr_gate_pkg::SEQ_INIT &&
                    seq_cnt_r == TW'(INIT_CYC - 1)) ||
                   (seq_r == sr_gate_pkg::SEQ_LOGIC &&
                    seq_cnt_r == TW'(sr_gate_pkg::LOGIC_INIT_CYC - 1));
   wire running = (seq_r == sr_gate_pkg::SEQ_RUN);

   always_comb begin
      seq_nxt = seq_r;
      case (seq_r)
         sr_gate_pkg::SEQ_OFF: if (supply_ok_r) seq_nxt = sr_gate_pkg::SEQ_INIT;
         sr_gate_pkg::SEQ_INIT: if (seq_done) seq_nxt = sr_gate_pkg::SEQ_LOGIC;
         sr_gate_pkg::SEQ_LOGIC: if (seq_done) seq_nxt = sr_gate_pkg::SEQ_RUN;
         default: seq_nxt = seq_r;
      endcase
      if (!supply_ok_nxt) seq_nxt = sr_gate_pkg::SEQ_OFF;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         supply_ok_r <= 1'b0;
         seq_r <= sr_gate_pkg::SEQ_OFF;
         seq_cnt_r <= '0;
      end else begin
         supply_ok_r <= supply_ok_nxt;
         seq_r <= seq_nxt;
         seq_cnt_r <= (seq_nxt != seq_r) ? '0 : seq_cnt_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // pulse qualification, blanking and sampling
   // ----------------------------------------------------------------
   logic above_r, qualified_r, armed_r;
   logic [LW-1:0] blank_cnt_r;
   logic [3:0] spl_cnt_r;
   logic [LW+7:0] peak_acc_r;
   wire above_now = primary_above_enable && primary_above_adaptive;
   wire rise = above_now && !above_r && running;
   wire fall = !above_now && above_r;
   wire blank_end = above_r && above_now && !qualified_r && running &&
                    blank_cnt_r == blanking_set_pin;
   wire [LW+7:0] thresh_prod = primary_level *
                               8'(sr_gate_pkg::THRESH_PCT);
   wire spl_last = level_sample_active &&
                   spl_cnt_r == 4'(sr_gate_pkg::SAMPLE_WIN_CYC - 1);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         above_r <= 1'b0;
         qualified_r <= 1'b0;
         blank_cnt_r <= '0;
         spl_cnt_r <= '0;
         level_sample_active <= 1'b0;
         adaptive_pulse_level <= '0;
         peak_acc_r <= '0;
         ramp_clear <= 1'b0;
         primary_ramp_run <= 1'b0;
         secondary_ramp_run <= 1'b0;
      end else begin
         above_r <= above_now;
         ramp_clear <= rise;
         if (rise) primary_ramp_run <= 1'b1;
         else if (fall || primary_ramp_saturated)
            primary_ramp_run <= 1'b0;
         if (rise) secondary_ramp_run <= 1'b1;
         else if (!gate_drive_out && !armed_r && !above_now)
            secondary_ramp_run <= 1'b0;
         if (rise || !above_now) blank_cnt_r <= '0;
         else if (!qualified_r) blank_cnt_r <= blank_cnt_r + 1'b1;
         if (rise) qualified_r <= 1'b0;
         else if (blank_end) qualified_r <= 1'b1;
         if (blank_end) begin
            level_sample_active <= 1'b1;
            spl_cnt_r <= '0;
            peak_acc_r <= '0;
         end else if (level_sample_active) begin
            spl_cnt_r <= spl_cnt_r + 1'b1;
            if (thresh_prod > peak_acc_r) peak_acc_r <= thresh_prod;
            if (spl_last) level_sample_active <= 1'b0;
         end
         if (spl_last)
            adaptive_pulse_level <= LW'((thresh_prod > peak_acc_r ?
                                 thresh_prod : peak_acc_r) / 100);
      end
   end

   // ----------------------------------------------------------------
   // gate drive, minimum on time, off blanking
   // ----------------------------------------------------------------
   logic [4:0] on_cnt_r;
   logic [7:0] off_cnt_r;
   logic off_block_r;
   wire min_on_done = on_cnt_r >= 5'(sr_gate_pkg::MIN_ON_CYC);
   wire drive_on = running && armed_r && !off_block_r && !standby_mode &&
                   output_above_enable && fall &&
                   primary_near_zero;
   wire drive_off = gate_drive_out && min_on_done && ramp_crossed;
   wire kill = !running || standby_mode;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         armed_r <= 1'b0;
         gate_drive_out <= 1'b0;
         on_cnt_r <= '0;
         off_cnt_r <= '0;
         off_block_r <= 1'b0;
         blank_reference_enable <= 1'b0;
      end else begin
         blank_reference_enable <= running;
         if (rise || kill) armed_r <= 1'b0;
         else if (blank_end && output_above_enable) armed_r <= 1'b1;
         else if (fall) armed_r <= 1'b0;
         if (kill) gate_drive_out <= 1'b0;
         else if (drive_on && !gate_drive_out) gate_drive_out <= 1'b1;
         else if (drive_off) gate_drive_out <= 1'b0;
         if (!gate_drive_out) on_cnt_r <= '0;
         else if (!min_on_done) on_cnt_r <= on_cnt_r + 1'b1;
         if (gate_drive_out && (drive_off || kill)) begin
            off_block_r <= 1'b1;
            off_cnt_r <= '0;
         end else if (off_block_r) begin
            off_cnt_r <= off_cnt_r + 1'b1;
            if (off_cnt_r == 8'(sr_gate_pkg::OFF_BLANK_CYC - 1))
               off_block_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // standby decision by switching frequency
   // ----------------------------------------------------------------
   logic [TW-1:0] win_cnt_r;
   logic [EW-1:0] evt_cnt_r;
   wire [TW-1:0] win_len = standby_mode ? TW'(EXIT_WIN_CYC - 1)
                                        : TW'(ENTRY_WIN_CYC - 1);
   wire win_end = win_cnt_r == win_len;
   wire exit_now = standby_mode && rise &&
                   evt_cnt_r >= EW'(sr_gate_pkg::EXIT_CYCLES);
   wire enter_now = !standby_mode && win_end &&
                    evt_cnt_r < EW'(sr_gate_pkg::ENTRY_CYCLES);

   always_ff @(posedge clk) begin
      if (sys_rst || !running) begin
         standby_mode <= 1'b0;
         win_cnt_r <= '0;
         evt_cnt_r <= '0;
      end else if (exit_now || win_end) begin
         standby_mode <= exit_now ? 1'b0 : enter_now ? 1'b1
                                                    : standby_mode;
         win_cnt_r <= '0;
         evt_cnt_r <= '0;
      end else begin
         win_cnt_r <= win_cnt_r + 1'b1;
         if (rise && evt_cnt_r != '1) evt_cnt_r <= evt_cnt_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_drive_needs_run: assert property (@(posedge clk) disable iff (sys_rst)
      gate_drive_out |-> $past(running)) else $error("drive outside run");
   a_min_on_hold: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(gate_drive_out) ##1 (running && !standby_mode) [*8] |->
      gate_drive_out) else $error("drive dropped early");
   a_off_blank: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(gate_drive_out) |-> !gate_drive_out [*8])
      else $error("turn on inside off blank");
   a_standby_off: assert property (@(posedge clk) disable iff (sys_rst)
      standby_mode |=> !gate_drive_out) else $error("drive in standby");
   a_supply_loss: assert property (@(posedge clk) disable iff (sys_rst)
      supply_drop |=> seq_r == sr_gate_pkg::SEQ_OFF ##1 !gate_drive_out)
      else $error("supply loss not handled");
   a_clear_on_rise: assert property (@(posedge clk) disable iff (sys_rst)
      rise |=> ramp_clear && primary_ramp_run) else $error("no clear");
   a_init_first: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(supply_ok_r) |=> !running [*8]) else $error("init skipped");
   a_sample_len: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(level_sample_active) |-> level_sample_active [*4] ##1
      !level_sample_active) else $error("sample window length");

   // ----------------------------------------------------------------
   // sequence and drive timing checks
   // ----------------------------------------------------------------
   // cycles since the drive last went low, saturating
   logic [7:0] since_off_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         since_off_r <= '1;
      end else if (gate_drive_out) begin
         since_off_r <= '0;
      end else if (since_off_r != '1) begin
         since_off_r <= since_off_r + 1'b1;
      end
   end

   a_off_since: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(gate_drive_out) |-> since_off_r >= 8'(sr_gate_pkg::OFF_BLANK_CYC))
      else $error("turn on before off blank ended");

   a_min_on_count: assert property (@(posedge clk) disable iff (sys_rst)
      gate_drive_out && !min_on_done && running && !standby_mode |=>
      gate_drive_out) else $error("drive off before minimum on time");

   a_supply_start: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(supply_ok_r) |-> $past(supply_above_start))
      else $error("supply valid below start level");

   a_ref_run: assert property (@(posedge clk) disable iff (sys_rst)
      blank_reference_enable |-> $past(running))
      else $error("blank reference before run");

   a_standby_reset: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(running) |=> !standby_mode)
      else $error("standby kept over restart");

   a_exit_fast: assert property (@(posedge clk) disable iff (sys_rst)
      exit_now |=> !standby_mode)
      else $error("standby exit delayed");

   // ----------------------------------------------------------------
   // pulse and ramp checks
   // ----------------------------------------------------------------
   a_drive_arm: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(gate_drive_out) |-> $past(armed_r))
      else $error("drive without qualified pulse");

   a_drive_zero: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(gate_drive_out) |-> $past(primary_near_zero))
      else $error("drive on away from zero");

   a_ramp_stop: assert property (@(posedge clk) disable iff (sys_rst)
      fall |=> !primary_ramp_run)
      else $error("primary ramp ran past fall");

   a_clear_one: assert property (@(posedge clk) disable iff (sys_rst)
      ramp_clear |=> !ramp_clear)
      else $error("ramp clear longer than one cycle");

   a_arm_blank: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(armed_r) |-> $past(blank_end))
      else $error("armed before blank end");
endmodule // sr_gate_timing_controller
`default_nettype wire

/* sr_gate_timing_controller_test.sv */
// self-checking testbench of the rectifier gate timing controller
`timescale 1ns/1ps
`default_nettype none
module sr_gate_timing_controller_test;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sup_on = 1'b0;
   logic sup_hold = 1'b0;
   logic out_en = 1'b0;
   logic fire = 1'b0;
   logic [7:0] on_cyc = 8'h00;
   logic [7:0] sec_cyc = 8'h02;
   logic [7:0] blank = 8'h08;
   logic sat = 1'b0;
   logic p_high, p_zero, crossed, drive, r_clr, p_run, s_run, smp;
   logic bref, stby;
   logic [7:0] p_lvl, adp;
   int err_total = 0;
   int checks = 0;
   int n_clr, n_smp, on_at, on_len, n, n_prun, n_srun;

   initial forever #12.5 clk = ~clk;

   sr_power_stage_model stage (.clk(clk), .fire(fire), .on_cyc(on_cyc),
      .sec_cyc(sec_cyc), .gate_drive_out(drive), .primary_high(p_high),
      .primary_near_zero(p_zero), .ramp_crossed(crossed),
      .primary_level(p_lvl));

   sr_gate_timing_controller #(.INIT_CYC(20), .ENTRY_WIN_CYC(3000),
      .EXIT_WIN_CYC(400)) uut (.clk(clk), .sys_rst(sys_rst),
      .supply_above_start(sup_on), .supply_above_stop(sup_hold),
      .primary_above_enable(p_high), .primary_above_adaptive(p_high),
      .primary_near_zero(p_zero), .output_above_enable(out_en),
      .ramp_crossed(crossed), .primary_ramp_saturated(sat),
      .primary_level(p_lvl), .blanking_set_pin(blank),
      .gate_drive_out(drive), .ramp_clear(r_clr),
      .primary_ramp_run(p_run), .secondary_ramp_run(s_run),
      .level_sample_active(smp), .blank_reference_enable(bref),
      .adaptive_pulse_level(adp), .standby_mode(stby));

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic fail(input string m);
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string m);
      checks++;
      if (got !== exp) fail(m);
   endtask

   task automatic chk_lvl(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) fail("adaptive level");
   endtask

   task automatic chk_cnt(input int got, input int lo, input int hi,
      input string m);
      checks++;
      if (got < lo || got > hi) fail(m);
   endtask

   task automatic pulse(input logic [7:0] len);
      @(posedge clk);
      on_cyc <= len;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask

   // bounded wait for ready (0), standby (1) or drive (2) to reach v
   task automatic wait_for(input int sel, input logic v, input int lim);
      for (n = 0; n < lim; n++) begin
         @(negedge clk);
         if ((sel == 0 ? bref : sel == 1 ? stby : drive) === v) return;
      end
      fail("wait ran out");
      give_verdict();
   endtask

   task automatic watch(input int lim);
      n_clr = 0;
      n_smp = 0;
      n_prun = 0;
      n_srun = 0;
      on_at = -1;
      on_len = 0;
      for (int i = 0; i < lim; i++) begin
         @(negedge clk);
         n_clr += (r_clr === 1'b1);
         n_smp += (smp === 1'b1);
         n_prun += (p_run === 1'b1);
         n_srun += (s_run === 1'b1);
         if (drive === 1'b1 && on_at < 0) on_at = i;
         on_len += (drive === 1'b1);
      end
   endtask

   task automatic t_startup();
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk_bit(drive, 1'b0, "drive after reset");
      @(posedge clk);
      sup_hold <= 1'b1;
      sup_on <= 1'b1;
      wait_for(0, 1'b1, 1000);
      chk_cnt(n, 820, 830, "init length");
      chk_bit(stby, 1'b0, "starts normal");
      pulse(8'h14);
      watch(60);
      chk_cnt(on_len, 0, 0, "drive without output sense");
      @(posedge clk);
      out_en <= 1'b1;
   endtask

   task automatic t_cycle();
      pulse(8'h14);
      watch(60);
      chk_cnt(n_clr, 1, 1, "ramp clear pulse");
      chk_cnt(n_smp, 4, 4, "sample window");
      chk_cnt(on_at, 20, 24, "turn on at fall");
      chk_cnt(on_len, 14, 16, "minimum on time");
      chk_cnt(n_prun, 19, 21, "primary ramp run");
      chk_cnt(n_srun, 16, 60, "secondary ramp run");
      chk_lvl(adp, 8'hAA);
      pulse(8'h14);
      watch(60);
      chk_cnt(on_len, 0, 0, "turn on inside off blank");
      repeat (180) @(posedge clk);
      blank <= 8'h20;
      pulse(8'h14);
      watch(60);
      chk_cnt(on_len, 0, 0, "pulse shorter than blank");
      blank <= 8'h08;
      pulse(8'h14);
      watch(60);
      chk_cnt(on_len, 14, 16, "drive after off blank");
      @(posedge clk);
      sat <= 1'b1;
      pulse(8'h14);
      watch(60);
      chk_cnt(n_prun, 1, 1, "ramp saturation");
      @(posedge clk);
      sat <= 1'b0;
   endtask

   task automatic t_supply();
      repeat (180) @(posedge clk);
      pulse(8'h14);
      wait_for(2, 1'b1, 40);
      @(posedge clk);
      sup_hold <= 1'b0;
      sup_on <= 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(drive, 1'b0, "drive kept on supply loss");
      chk_bit(bref, 1'b0, "sequencer kept running");
      @(posedge clk);
      sup_hold <= 1'b1;
      repeat (900) @(negedge clk);
      chk_bit(bref, 1'b0, "restart below start level");
      @(posedge clk);
      sup_on <= 1'b1;
      wait_for(0, 1'b1, 1000);
      chk_cnt(n, 820, 830, "restart init length");
   endtask

   task automatic t_standby();
      int k;
      wait_for(1, 1'b1, 7000);
      chk_bit(stby, 1'b1, "standby entry");
      pulse(8'h14);
      watch(60);
      chk_cnt(on_len, 0, 0, "drive in standby");
      for (k = 0; k < 200 && stby !== 1'b0; k++) begin
         pulse(8'h01);
         @(negedge clk);
      end
      chk_bit(stby, 1'b0, "standby exit");
      chk_cnt(k, 31, 199, "exit count");
   endtask

   initial begin
      t_startup();
      t_cycle();
      t_supply();
      t_standby();
      give_verdict();
   end
endmodule // sr_gate_timing_controller_test
`default_nettype wire

/* sr_power_stage_model.sv */
// flyback power stage and rectifier switch model
`timescale 1ns/1ps
`default_nettype none
module sr_power_stage_model #(
   parameter logic [7:0] PEAK = 8'hC8
) (
   input wire logic clk,
   input wire logic fire,
   input wire logic [7:0] on_cyc,
   input wire logic [7:0] sec_cyc,
   input wire logic gate_drive_out,
   output logic primary_high,
   output logic primary_near_zero,
   output logic ramp_crossed,
   output logic [7:0] primary_level
);
   logic [7:0] pri_r = 8'h00;
   logic [7:0] sec_r = 8'h00;
   // primary conduction length, then a clean fall to zero
   always_ff @(posedge clk) begin
      if (fire) begin
         pri_r <= on_cyc;
      end else if (pri_r != 8'h00) begin
         pri_r <= pri_r - 8'h01;
      end
      sec_r <= gate_drive_out ? sec_r + 8'h01 : 8'h00;
   end
   assign primary_high = (pri_r != 8'h00);
   assign primary_near_zero = !primary_high;
   assign ramp_crossed = gate_drive_out && (sec_r >= sec_cyc);
   assign primary_level = primary_high ? PEAK : 8'h00;
endmodule // sr_power_stage_model
`default_nettype wire
